// ---- src/upc_clock_ctrl.sv ----
// Clock controller: SFR block, clock enable generation, PLL digital part.
// Assumes synchronous SFR strobes from the CPU and an analog VCO/lock detector outside.
`timescale 1ns/1ps
`include "upc_consts.svh"

module upc_clock_ctrl
  import upc_pkg::*;
(
  input wire logic REF_CLK, // Oscillator clock, 50 MHz
  input wire logic RST_N, // Async reset, active low
  input wire logic [7:0] SFR_ADDR, // SFR address
  input wire logic SFR_WR, // SFR write strobe
  input wire logic SFR_RD, // SFR read strobe
  input wire logic [7:0] SFR_WDATA, // SFR write data
  input wire logic IDLE_MODE, // Idle: CPU frozen
  input wire logic POWER_DOWN, // Power-down: all frozen
  input wire logic VCO_TICK, // One pulse per VCO edge
  input wire logic LOCK_DET, // Raw analog lock detector
  output logic [7:0] SFR_RDATA, // Read data, one cycle after read
  output upc_clk_en_type CLK_EN, // CPU, peripheral, USB clock enables
  output logic [`UPC_NUM_PERIPH-1:0] PER_TICK, // Per-peripheral ticks
  output logic OSC_ENABLE, // Oscillator inverter enable
  output logic USB_FROM_PLL, // USB clock taken from PLL
  output logic PLL_RUN, // PLL generation enable
  output upc_pump_type PUMP // Charge pump up/down pulses
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] speed0; // Double speed and speed bits
  logic [7:0] speed1; // Serial peripheral speed bit
  logic bypass; // External 48 MHz bypass
  logic pll_enable_bit; // PLL enable
  logic [3:0] div_r; // Feedback divider setting
  logic [3:0] div_n; // Reference divider setting
  logic [7:0] rdata; // Read data register
  logic [7:0] next_speed0;
  logic [7:0] next_speed1;
  logic next_bypass;
  logic next_pll_enable_bit;
  logic [3:0] next_div_r;
  logic [3:0] next_div_n;
  logic [7:0] next_rdata;
  logic pll_lock_flag; // Synchronised lock status

  // Write and read decode
  always_comb begin
    next_speed0 = speed0;
    next_speed1 = speed1;
    next_bypass = bypass;
    next_pll_enable_bit = pll_enable_bit;
    next_div_r = div_r;
    next_div_n = div_n;
    next_rdata = rdata;
    if (SFR_WR) begin
      if (SFR_ADDR == `UPC_ADDR_SPEED0) begin
        next_speed0 = SFR_WDATA & `UPC_MASK_SPEED0;
      end else if (SFR_ADDR == `UPC_ADDR_SPEED1) begin
        next_speed1 = SFR_WDATA & `UPC_MASK_SPEED1;
      end else if (SFR_ADDR == `UPC_ADDR_PLL_CTRL) begin
        // Lock bit is status only; writes to it are dropped
        next_bypass = SFR_WDATA[`UPC_BIT_BYPASS];
        next_pll_enable_bit = SFR_WDATA[`UPC_BIT_PLL_ENABLE];
      end else if (SFR_ADDR == `UPC_ADDR_PLL_DIV) begin
        next_div_r = SFR_WDATA[7:4]; // RULE10
        next_div_n = SFR_WDATA[3:0]; // RULE10
      end
    end
    if (SFR_RD) begin
      if (SFR_ADDR == `UPC_ADDR_SPEED0) begin
        next_rdata = speed0;
      end else if (SFR_ADDR == `UPC_ADDR_SPEED1) begin
        next_rdata = speed1;
      end else if (SFR_ADDR == `UPC_ADDR_PLL_CTRL) begin
        next_rdata = {5'h00, bypass, pll_enable_bit, pll_lock_flag};
      end else if (SFR_ADDR == `UPC_ADDR_PLL_DIV) begin
        next_rdata = {div_r, div_n}; // RULE10
      end else begin
        // Unmapped SFRs belong to other blocks; answer zero
        next_rdata = `UPC_RST_BYTE;
      end
    end
  end

  // Register update
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      speed0 <= `UPC_RST_BYTE;
      speed1 <= `UPC_RST_BYTE;
      bypass <= 1'b0;
      pll_enable_bit <= 1'b0;
      div_r <= `UPC_RST_NIB;
      div_n <= `UPC_RST_NIB;
      rdata <= `UPC_RST_BYTE;
    end else begin
      speed0 <= next_speed0;
      speed1 <= next_speed1;
      bypass <= next_bypass;
      pll_enable_bit <= next_pll_enable_bit;
      div_r <= next_div_r;
      div_n <= next_div_n;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock enable generation
  logic half; // Toggles each cycle: half-rate phase
  logic next_half;
  logic double_speed_select; // Double speed select
  logic [`UPC_NUM_PERIPH-1:0] speed_bits; // Per-peripheral speed bits
  logic [`UPC_NUM_PERIPH-1:0] next_tick;
  upc_clk_en_type clk_en;
  upc_clk_en_type next_clk_en;
  logic osc_enable;
  logic next_osc_enable;
  logic usb_from_pll;
  logic next_usb_from_pll;

  assign double_speed_select = speed0[`UPC_BIT_DBL_SPEED];
  assign speed_bits = {speed1[0], speed0[6:1]};

  // Full rate in double speed with the speed bit clear, else every other cycle
  function automatic logic rate_tick(input logic dbl, input logic slow, input logic ph);
    rate_tick = (dbl & ~slow) | ph;
  endfunction

  // Speed bits only matter with double speed set
  genvar gi;
  generate
    for (gi = 0; gi < `UPC_NUM_PERIPH; gi++) begin : g_tick
      assign next_tick[gi] = ~POWER_DOWN &
        rate_tick(double_speed_select, speed_bits[gi], next_half); // RULE14
    end
  endgenerate

  // Mode gating and source selection
  always_comb begin
    next_half = ~half;
    // CPU stops in idle and power-down; peripherals only in power-down
    next_clk_en.cpu = ~IDLE_MODE & ~POWER_DOWN &
      rate_tick(double_speed_select, 1'b0, next_half); // RULE1 RULE2 RULE13
    next_clk_en.per = ~POWER_DOWN &
      rate_tick(double_speed_select, 1'b0, next_half); // RULE1 RULE2 RULE13
    // USB source runs at its own rate; gated only in power-down
    next_clk_en.usb = ~POWER_DOWN; // RULE1 RULE2
    // Crystal inverter only needed while PLL feeds USB
    next_osc_enable = ~bypass; // RULE3 RULE4 RULE11
    next_usb_from_pll = ~bypass; // RULE11
  end

  // Clock enable registers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      half <= 1'b0;
      clk_en <= '0;
      PER_TICK <= '0;
      osc_enable <= 1'b1;
      usb_from_pll <= 1'b1;
    end else begin
      half <= next_half;
      clk_en <= next_clk_en;
      PER_TICK <= next_tick;
      osc_enable <= next_osc_enable;
      usb_from_pll <= next_usb_from_pll;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL dividers, phase detector and lock tracking
  logic pll_run; // Generation enable
  logic next_pll_run;
  logic [3:0] cnt_n; // Reference divider count
  logic [3:0] cnt_r; // Feedback divider count
  logic [3:0] next_cnt_n;
  logic [3:0] next_cnt_r;
  logic ref_edge; // Reference divider terminal count
  logic fb_edge; // Feedback divider terminal count
  upc_pump_type pump;
  upc_pump_type next_pump;
  logic lock_meta; // First synchroniser stage
  logic lock_sync; // Second synchroniser stage
  upc_pll_state_type pll_state;
  upc_pll_state_type next_pll_state;

  // Reference is the peripheral clock rate
  assign ref_edge = next_clk_en.per & (cnt_n == div_n);
  assign fb_edge = VCO_TICK & (cnt_r == div_r);

  // Divider and detector next values
  always_comb begin
    next_pll_run = pll_enable_bit & ~bypass; // RULE5 RULE11
    next_cnt_n = cnt_n;
    next_cnt_r = cnt_r;
    next_pump = pump;
    if (!pll_run) begin
      // Stopped PLL: dividers and pump held idle
      next_cnt_n = 4'h0;
      next_cnt_r = 4'h0;
      next_pump = '0; // RULE5
    end else begin
      if (next_clk_en.per) begin
        next_cnt_n = ref_edge ? 4'h0 : cnt_n + 4'h1;
      end
      if (VCO_TICK) begin
        next_cnt_r = fb_edge ? 4'h0 : cnt_r + 4'h1;
      end
      // Leading edge raises its pump line, trailing edge resets both
      next_pump.up = (pump.up | ref_edge) & ~(pump.down | fb_edge); // RULE8
      next_pump.down = (pump.down | fb_edge) & ~(pump.up | ref_edge); // RULE8
    end
    // Lock tracking state
    case (pll_state)
      UPC_PLL_OFF: next_pll_state = pll_run ? UPC_PLL_ACQUIRE : UPC_PLL_OFF;
      UPC_PLL_ACQUIRE: next_pll_state = !pll_run ? UPC_PLL_OFF :
        (lock_sync ? UPC_PLL_LOCKED : UPC_PLL_ACQUIRE); // RULE6
      UPC_PLL_LOCKED: next_pll_state = !pll_run ? UPC_PLL_OFF :
        (lock_sync ? UPC_PLL_LOCKED : UPC_PLL_ACQUIRE); // RULE12
      default: next_pll_state = UPC_PLL_OFF;
    endcase
  end

  // PLL registers; first detector stage read only by the second, second read by the lock state machine
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pll_run <= 1'b0;
      cnt_n <= 4'h0;
      cnt_r <= 4'h0;
      pump <= '0;
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      pll_state <= UPC_PLL_OFF;
    end else begin
      pll_run <= next_pll_run;
      cnt_n <= next_cnt_n;
      cnt_r <= next_cnt_r;
      pump <= next_pump;
      lock_meta <= LOCK_DET; // RULE15
      lock_sync <= lock_meta; // RULE15
      pll_state <= next_pll_state;
    end
  end

  // Lock flag follows the state; software cannot write it
  assign pll_lock_flag = (pll_state == UPC_PLL_LOCKED); // RULE6 RULE12

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops
  assign SFR_RDATA = rdata;
  assign CLK_EN = clk_en;
  assign OSC_ENABLE = osc_enable;
  assign USB_FROM_PLL = usb_from_pll;
  assign PLL_RUN = pll_run;
  assign PUMP = pump;

endmodule

// ---- shared/upc_consts.svh ----
// Constants of the USB PLL clock controller: SFR addresses, bit positions, resets.
// Assumes an 8-bit SFR space addressed by the CPU core of the device.
// Operation
// RULE1: Produce separate CPU, peripheral and USB clocks
// RULE2: Gate each clock by power reduction mode
// RULE3: Source is crystal or external 48 MHz
// RULE4: Oscillator inverter off unless PLL feeds USB
// RULE5: PLL runs only while enable bit set
// RULE6: Lock flag set when detector reports lock
// RULE7: Firmware polls lock flag before using PLL
// RULE8: PFD compares N reference against R feedback
// RULE9: Firmware picks dividers giving 48 MHz output
// RULE10: Divider register holds R high, N low
// RULE11: Bypass bit skips PLL, stops crystal oscillator
// RULE12: Lock flag cleared when PLL loses lock
// RULE13: Double speed bit picks full or half rate
// RULE14: Peripheral speed bits act only in double speed
// RULE15: Lock detector synchronised through two flip-flops
`ifndef UPC_CONSTS_SVH
`define UPC_CONSTS_SVH

// SFR addresses
`define UPC_ADDR_SPEED0 8'h8F
`define UPC_ADDR_SPEED1 8'hAF
`define UPC_ADDR_PLL_CTRL 8'hA3
`define UPC_ADDR_PLL_DIV 8'hA4

// Control and speed 0 register bit positions
`define UPC_BIT_BYPASS 2
`define UPC_BIT_PLL_ENABLE 1
`define UPC_BIT_LOCK 0
`define UPC_BIT_DBL_SPEED 0

// Writable masks; reserved bits read as zero
`define UPC_MASK_SPEED0 8'h7F
`define UPC_MASK_SPEED1 8'h01
`define UPC_MASK_PLL_CTRL 8'h06

// Reset values
`define UPC_RST_BYTE 8'h00
`define UPC_RST_NIB 4'h0

// Number of per-peripheral speed bits (six in speed 0, one in speed 1)
`define UPC_NUM_PERIPH 7

`endif

// ---- shared/upc_pkg.sv ----
// Types of the USB PLL clock controller.
// Assumes upc_consts.svh holds all numeric constants.
package upc_pkg;

  // Gated clock enables
  typedef struct packed {
    logic cpu;
    logic per;
    logic usb;
  } upc_clk_en_type;

  // Charge pump commands from the phase detector
  typedef struct packed {
    logic up;
    logic down;
  } upc_pump_type;

  // PLL lock state, one-hot
  typedef enum logic [2:0] {
    UPC_PLL_OFF = 3'b001,
    UPC_PLL_ACQUIRE = 3'b010,
    UPC_PLL_LOCKED = 3'b100
  } upc_pll_state_type;

endpackage

// ---- tb/upc_clock_ctrl_sva.sv ----
// Checker for the clock controller ports.
// Assumes it is bound onto every upc_clock_ctrl instance.
`timescale 1ns/1ps
`include "upc_consts.svh"
module upc_clock_ctrl_sva
  import upc_pkg::*;
(
  input wire logic REF_CLK, // Clock
  input wire logic RST_N, // Reset, low
  input wire logic [7:0] SFR_ADDR, // Address
  input wire logic SFR_WR, // Write
  input wire logic SFR_RD, // Read
  input wire logic [7:0] SFR_WDATA, // Write data
  input wire logic IDLE_MODE, // Idle
  input wire logic POWER_DOWN, // Power-down
  input wire logic LOCK_DET, // Raw lock
  input wire logic [7:0] SFR_RDATA, // Read data
  input wire upc_clk_en_type CLK_EN, // Enables
  input wire logic [`UPC_NUM_PERIPH-1:0] PER_TICK, // Ticks
  input wire logic OSC_ENABLE, // Oscillator
  input wire logic USB_FROM_PLL, // USB source
  input wire logic PLL_RUN, // PLL on
  input wire upc_pump_type PUMP // Pump
);
  ////////////////////////////////
  // One domain, so one clocking and one reset
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Control register accesses
  sequence s_ctl_wr;
    SFR_WR && SFR_ADDR == `UPC_ADDR_PLL_CTRL;
  endsequence
  sequence s_ctl_rd;
    SFR_RD && SFR_ADDR == `UPC_ADDR_PLL_CTRL;
  endsequence
  a_run_after_wr: assert property (
    // Control bits register at the write edge, run follows one edge later
    s_ctl_wr |-> ##2 PLL_RUN == ($past(SFR_WDATA[1], 2) && !$past(SFR_WDATA[2], 2)))
    else $error("pll run wrong after write");
  a_osc_by_bypass: assert property (
    s_ctl_wr |-> ##2 OSC_ENABLE == !$past(SFR_WDATA[2], 2) && USB_FROM_PLL == OSC_ENABLE)
    else $error("oscillator wrong after write");
  a_run_needs_osc: assert property (PLL_RUN |-> OSC_ENABLE)
    else $error("pll runs in bypass");
  a_pump_excl: assert property (!(PUMP.up && PUMP.down))
    else $error("pump up and down together");
  a_pump_quiet: assert property (!PLL_RUN [*3] |-> PUMP == 2'b00)
    else $error("pump active while stopped");
  a_pd_gates: assert property (
    POWER_DOWN [*2] |-> CLK_EN == 3'b000 && PER_TICK == '0)
    else $error("clock alive in power-down");
  a_idle_cpu: assert property (IDLE_MODE [*2] |-> !CLK_EN.cpu)
    else $error("cpu clock alive in idle");
  a_lock_drops: assert property (
    (!LOCK_DET [*6] ##0 s_ctl_rd) |=> !SFR_RDATA[0])
    else $error("lock flag kept after loss");
endmodule
bind upc_clock_ctrl upc_clock_ctrl_sva upc_clock_ctrl_sva_inst (.*);

// ---- tb/usb_pll_clock_controller_tb.sv ----
// Testbench: SFR access, clock rates, power modes, PLL control.
// Assumes design, package and checker are compiled first.
`timescale 1ns/1ps
`include "upc_consts.svh"
module usb_pll_clock_controller_tb
  import upc_pkg::*;
;
  logic clk, rst_n, wr, rd, idle, pd, vco, lock;
  logic [7:0] addr, wdata, rdata;
  logic [6:0] tick;
  logic osc, usbp, run;
  upc_clk_en_type en;
  upc_pump_type pump;
  int err_count = 0;
  int n_checks = 0;
  int c [8]; // cpu, per, usb, t0, t1, pump up, pump down, ticks t2-t6
  // Device; VCO ticks run only in the pump scenario
  upc_clock_ctrl upc_clock_ctrl_inst (.REF_CLK(clk), .RST_N(rst_n), .SFR_ADDR(addr),
    .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata), .IDLE_MODE(idle), .POWER_DOWN(pd),
    .VCO_TICK(vco), .LOCK_DET(lock), .SFR_RDATA(rdata), .CLK_EN(en), .PER_TICK(tick),
    .OSC_ENABLE(osc), .USB_FROM_PLL(usbp), .PLL_RUN(run), .PUMP(pump));
  ////////////////////////////////
  // Byte compare, counted
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle write strobe
  task automatic wr_sfr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr = 1;
    @(posedge clk);
    #1 wr = 0;
  endtask
  // One-cycle read; data stands after the taking edge
  task automatic rd_sfr(input logic [7:0] a);
    @(posedge clk);
    #1 addr = a;
    rd = 1;
    @(posedge clk);
    #1 rd = 0;
  endtask
  // Read and judge the byte
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd_sfr(a);
    chk("sfr read", exp, rdata);
  endtask
  // Count enables over n cycles; two idle edges let modes settle
  task automatic count(input int n);
    c = '{default: 0};
    repeat (2) @(posedge clk);
    repeat (n) begin
      @(posedge clk);
      #1 c[0] += en.cpu;
      c[1] += en.per;
      c[2] += en.usb;
      c[3] += tick[0];
      c[4] += tick[1];
      c[5] += pump.up;
      c[6] += pump.down;
      c[7] += $countones(tick[6:2]);
    end
  endtask
  // Oscillator, USB source, PLL run, one edge after a write
  task automatic pins(input logic [2:0] exp);
    @(posedge clk);
    #1 chk("osc usb run", {5'h0, exp}, {5'h0, osc, usbp, run});
  endtask
  ////////////////////////////////
  // Reset values, writable masks, an unmapped place, divider settings
  task automatic t_regs();
    logic [7:0] a [5] = '{`UPC_ADDR_SPEED0, `UPC_ADDR_SPEED1, `UPC_ADDR_PLL_CTRL,
      `UPC_ADDR_PLL_DIV, 8'hA2};
    logic [7:0] m [5] = '{`UPC_MASK_SPEED0, `UPC_MASK_SPEED1, `UPC_MASK_PLL_CTRL, 8'hFF, 8'h00};
    logic [7:0] dv [3] = '{8'h30, 8'h10, 8'hB9};
    for (int i = 0; i < 5; i++) begin
      rd_chk(a[i], 8'h00);
      wr_sfr(a[i], 8'hFF);
      rd_chk(a[i], m[i]);
      wr_sfr(a[i], 8'h00);
    end
    foreach (dv[i]) begin
      wr_sfr(`UPC_ADDR_PLL_DIV, dv[i]);
      rd_chk(`UPC_ADDR_PLL_DIV, dv[i]);
    end
  endtask
  // Half and full rate; speed bits count only in double speed
  task automatic t_rate();
    logic [7:0] cfg [3] = '{8'h00, 8'h03, 8'h02};
    logic [7:0] r [3] = '{8'h0A, 8'h14, 8'h0A};
    // Five ticks with clear speed bits: half rate unless double speed
    logic [7:0] rr [3] = '{8'h32, 8'h64, 8'h32};
    foreach (cfg[i]) begin
      wr_sfr(`UPC_ADDR_SPEED0, cfg[i]);
      count(20);
      chk("cpu rate", r[i], 8'(c[0]));
      chk("per rate", r[i], 8'(c[1]));
      chk("t0 rate", 8'h0A, 8'(c[3]));
      chk("t1 rate", r[i], 8'(c[4]));
      chk("t2-6 rate", rr[i], 8'(c[7]));
    end
  endtask
  // Idle stops the CPU only, power-down stops per, usb, t0 and t2-t6
  task automatic t_modes();
    wr_sfr(`UPC_ADDR_SPEED0, 8'h01);
    idle = 1;
    count(20);
    chk("idle cpu", 8'h00, 8'(c[0]));
    chk("idle per", 8'h14, 8'(c[1]));
    chk("idle usb", 8'h14, 8'(c[2]));
    idle = 0;
    pd = 1;
    count(20);
    chk("pd clocks", 8'h00, 8'(c[1] + c[2] + c[3] + c[7]));
    pd = 0;
    wr_sfr(`UPC_ADDR_SPEED0, 8'h00);
  endtask
  // Enable, lock through the synchroniser, loss, bypass
  task automatic t_pll();
    wr_sfr(`UPC_ADDR_PLL_DIV, 8'h30);
    wr_sfr(`UPC_ADDR_PLL_CTRL, 8'h02);
    pins(3'b111);
    lock = 1;
    rd_chk(`UPC_ADDR_PLL_CTRL, 8'h02);
    count(6);
    chk("pump up", 8'h01, {7'h0, c[5] != 0});
    rd_chk(`UPC_ADDR_PLL_CTRL, 8'h03);
    lock = 0;
    count(4);
    rd_chk(`UPC_ADDR_PLL_CTRL, 8'h02);
    wr_sfr(`UPC_ADDR_PLL_CTRL, 8'h06);
    pins(3'b000);
    lock = 1;
    wr_sfr(`UPC_ADDR_PLL_CTRL, 8'h00);
    pins(3'b110);
    rd_chk(`UPC_ADDR_PLL_CTRL, 8'h00);
    lock = 0;
  endtask
  // Feedback every cycle, reference every other: pump pulls down only
  task automatic t_pump();
    int k = 0;
    wr_sfr(`UPC_ADDR_PLL_DIV, 8'h00);
    vco = 1;
    lock = 1;
    wr_sfr(`UPC_ADDR_PLL_CTRL, 8'h02);
    // Firmware waits for the lock flag, bounded to eight reads
    do begin
      rd_sfr(`UPC_ADDR_PLL_CTRL);
      k++;
    end while (rdata[0] !== 1'b1 && k < 8);
    chk("lock poll", 8'h03, rdata);
    count(20);
    chk("pump down", 8'h0A, 8'(c[6]));
    chk("pump up", 8'h00, 8'(c[5]));
    wr_sfr(`UPC_ADDR_PLL_CTRL, 8'h00);
    count(4);
    chk("pump stop", 8'h00, 8'(c[5] + c[6]));
    vco = 0;
    lock = 0;
  endtask
  ////////////////////////////////
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Clock, 20 ns period
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #100000;
    err_count++;
    final_report();
  end
  // Reset for four cycles, then the scenarios
  initial begin
    rst_n = 0;
    {wr, rd, idle, pd, vco, lock, addr, wdata} = '0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    t_regs();
    t_rate();
    t_modes();
    t_pll();
    t_pump();
    final_report();
  end
endmodule
